/* File: logic/timer_pkg.sv */
// Constants, types and register map of the prescaled reload timer
package timer_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_CTRL   = 3'h0;
  localparam logic [2:0] ADDR_IOC    = 3'h1;
  localparam logic [2:0] ADDR_MODE   = 3'h2;
  localparam logic [2:0] ADDR_PRE    = 3'h3;
  localparam logic [2:0] ADDR_CNT    = 3'h4;
  localparam logic [2:0] ADDR_ROUTE  = 3'h5;

  // ----------------------------------------------------------------
  // Control and route register fields
  // ----------------------------------------------------------------
  localparam int CTRL_START_BIT  = 0;
  localparam int CTRL_STATUS_BIT = 1;
  localparam int CTRL_FSTOP_BIT  = 2;
  localparam int CTRL_EDGE_BIT   = 4;
  localparam int CTRL_UNDF_BIT   = 5;
  localparam int ROUTE_OSEL_BIT  = 0;

  // ----------------------------------------------------------------
  // Reset values and divider terminal counts
  // ----------------------------------------------------------------
  localparam logic [7:0] CNT_RESET  = 8'hFF;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  localparam logic [4:0] DIV32_LAST = 5'h1F;
  localparam logic [2:0] DIV8_LAST  = 3'h7;

  typedef enum logic [2:0] {
    MODE_TIMER  = 3'h0,
    MODE_PULSE  = 3'h1,
    MODE_EVENT  = 3'h2,
    MODE_WIDTH  = 3'h3,
    MODE_PERIOD = 3'h4
  } op_mode_t;

  typedef enum logic [2:0] {
    SRC_DIV_ONE   = 3'h0,
    SRC_DIV_TWO   = 3'h1,
    SRC_DIV_EIGHT = 3'h2,
    SRC_ONCHIP    = 3'h3,
    SRC_SUB32     = 3'h4
  } clk_src_t;

  typedef enum logic [1:0] {
    FILT_OFF = 2'h0,
    FILT_F1  = 2'h1,
    FILT_F8  = 2'h2,
    FILT_F32 = 2'h3
  } filt_cfg_t;

  // One-bit steps idle -> latch -> reload, then both bits clear back to idle
  typedef enum logic [1:0] {
    PER_IDLE   = 2'b00,
    PER_LATCH  = 2'b01,
    PER_RELOAD = 2'b11
  } period_state_t;

  typedef struct packed {
    filt_cfg_t filter_cfg;
    logic      input_pin_select_bit;
    logic      inverted_out_enable_bit;
    logic      output_stop_bit;
    logic      edge_level_select_bit;
  } io_ctrl_t;

  typedef struct packed {
    clk_src_t clk_src;
    op_mode_t op_mode;
  } mode_cfg_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

endpackage

/* File: logic/reload_timer.sv */
// Prescaled reload timer with pulse, event and measurement modes
`timescale 1ns/1ps
module reload_timer
  import timer_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire reg_req_t   bus_req,
  output logic [7:0]      rdata,
  input  wire logic       onchip_osc_clock,
  input  wire logic       subclock_tick,
  input  wire logic       pin_a_in,
  output logic            pin_a_out,
  output logic            pin_a_oe_n,
  input  wire logic       pin_b_in,
  output logic            pin_b_out,
  output logic            pin_b_oe_n,
  output logic            inv_a_out,
  output logic            inv_a_oe_n,
  output logic            inv_b_out,
  output logic            inv_b_oe_n,
  output logic            timer_irq
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic          start_ff;
  logic          status_ff;
  logic          edge_found_ff;
  logic          underflow_ff;
  io_ctrl_t      ioc_ff;
  mode_cfg_t     mode_ff;
  logic          out_pin_select_ff;
  logic [7:0]    pre_cnt_ff;
  logic [7:0]    pre_rld_ff;
  logic          pre_pend_ff;
  logic [7:0]    tmr_cnt_ff;
  logic [7:0]    tmr_rld_ff;
  logic          tmr_pend_ff;
  logic [7:0]    buf_ff;
  logic          buf_held_ff;
  period_state_t per_state_ff;
  logic          out_lvl_ff;
  logic          irq_ff;
  logic [7:0]    rdata_ff;

  logic ctrl_wr;
  logic ioc_wr;
  logic mode_wr;
  logic pre_wr;
  logic cnt_wr;
  logic force_stop;
  logic stopped;

  assign ctrl_wr    = bus_req.wr && (bus_req.addr == ADDR_CTRL);
  assign ioc_wr     = bus_req.wr && (bus_req.addr == ADDR_IOC);
  assign mode_wr    = bus_req.wr && (bus_req.addr == ADDR_MODE);
  assign pre_wr     = bus_req.wr && (bus_req.addr == ADDR_PRE);
  assign cnt_wr     = bus_req.wr && (bus_req.addr == ADDR_CNT);
  assign force_stop = ctrl_wr && bus_req.wdata[CTRL_FSTOP_BIT];
  assign stopped    = !start_ff && !status_ff;

  // ----------------------------------------------------------------
  // Internal count sources
  // ----------------------------------------------------------------
  logic [4:0] div_cnt_ff;
  logic [4:0] sub_cnt_ff;
  logic       int_tick;
  logic       div8_tick;
  logic       div32_tick;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      div_cnt_ff <= 5'h00;
      sub_cnt_ff <= 5'h00;
    end else begin
      div_cnt_ff <= div_cnt_ff + 5'h01;
      if (subclock_tick) begin
        sub_cnt_ff <= sub_cnt_ff + 5'h01;
      end
    end
  end

  assign div8_tick  = (div_cnt_ff[2:0] == DIV8_LAST);
  assign div32_tick = (div_cnt_ff == DIV32_LAST);

  always_comb begin
    case (mode_ff.clk_src)
      SRC_DIV_ONE:   int_tick = 1'b1;
      SRC_DIV_TWO:   int_tick = div_cnt_ff[0];
      SRC_DIV_EIGHT: int_tick = div8_tick;
      SRC_ONCHIP:    int_tick = onchip_osc_clock;
      SRC_SUB32:     int_tick = subclock_tick && (sub_cnt_ff == DIV32_LAST);
      default:       int_tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Input path: pin select, synchroniser, filter, edges
  // ----------------------------------------------------------------
  logic       sync1_ff;
  logic       sync2_ff;
  logic [1:0] samp_ff;
  logic       filt_ff;
  logic       filt_prev_ff;
  logic       samp_en;
  logic       rise;
  logic       fall;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= ioc_ff.input_pin_select_bit ? pin_b_in : pin_a_in;
      sync2_ff <= sync1_ff;
    end
  end

  always_comb begin
    case (ioc_ff.filter_cfg)
      FILT_F1:  samp_en = 1'b1;
      FILT_F8:  samp_en = div8_tick;
      FILT_F32: samp_en = div32_tick;
      default:  samp_en = 1'b0;
    endcase
  end

  // Three equal samples in a row are needed before the level moves
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      samp_ff      <= 2'b00;
      filt_ff      <= 1'b0;
      filt_prev_ff <= 1'b0;
    end else begin
      filt_prev_ff <= filt_ff;
      if (ioc_ff.filter_cfg == FILT_OFF) begin
        filt_ff <= sync2_ff;
      end else if (samp_en) begin
        samp_ff <= {samp_ff[0], sync2_ff};
        if (samp_ff == {2{sync2_ff}}) begin
          filt_ff <= sync2_ff;
        end
      end
    end
  end

  assign rise = filt_ff && !filt_prev_ff;
  assign fall = !filt_ff && filt_prev_ff;

  // Edge select: 0 rising / high level, 1 falling / low level
  logic active_edge;
  logic level_match;
  logic width_end;
  assign active_edge = ioc_ff.edge_level_select_bit ? fall : rise;
  assign level_match = filt_ff ^ ioc_ff.edge_level_select_bit;
  assign width_end   = ioc_ff.edge_level_select_bit ? rise : fall;

  // ----------------------------------------------------------------
  // Count enable per mode
  // ----------------------------------------------------------------
  logic cnt_tick;
  logic count_en;

  always_comb begin
    case (mode_ff.op_mode)
      MODE_EVENT: cnt_tick = active_edge;
      MODE_WIDTH: cnt_tick = int_tick && level_match;
      default:    cnt_tick = int_tick;
    endcase
  end
  assign count_en = status_ff && cnt_tick;

  // ----------------------------------------------------------------
  // Start, status and flags
  // ----------------------------------------------------------------
  logic pre_unf;
  logic tmr_unf;
  logic per_reload;
  logic meas_end;
  logic per_mode;

  assign per_mode = (mode_ff.op_mode == MODE_PERIOD);
  assign meas_end = status_ff && (((mode_ff.op_mode == MODE_WIDTH) &&
                    width_end) || (per_mode && active_edge));

  always_ff @(posedge ref_clk) begin
    if (!nrst || force_stop) begin
      start_ff  <= 1'b0;
      status_ff <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        start_ff <= bus_req.wdata[CTRL_START_BIT];
      end
      status_ff <= start_ff;
    end
  end

  // Hardware set wins over a clearing write in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      edge_found_ff <= 1'b0;
      underflow_ff  <= 1'b0;
    end else begin
      if (per_reload || (meas_end && !per_mode)) begin
        edge_found_ff <= 1'b1;
      end else if (ctrl_wr && !bus_req.wdata[CTRL_EDGE_BIT]) begin
        edge_found_ff <= 1'b0;
      end
      if (tmr_unf) begin
        underflow_ff <= 1'b1;
      end else if (ctrl_wr && !bus_req.wdata[CTRL_UNDF_BIT]) begin
        underflow_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ioc_ff            <= '0;
      mode_ff           <= '0;
      out_pin_select_ff <= 1'b0;
    end else begin
      if (ioc_wr) begin
        ioc_ff <= io_ctrl_t'(bus_req.wdata[5:0]);
      end
      if (mode_wr && stopped) begin
        mode_ff <= mode_cfg_t'(bus_req.wdata[5:0]);
      end
      if (bus_req.wr && (bus_req.addr == ADDR_ROUTE)) begin
        out_pin_select_ff <= bus_req.wdata[ROUTE_OSEL_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  assign pre_unf = count_en && !pre_pend_ff && (pre_cnt_ff == BYTE_ZERO);

  always_ff @(posedge ref_clk) begin
    if (!nrst || force_stop) begin
      pre_cnt_ff  <= CNT_RESET;
      pre_rld_ff  <= CNT_RESET;
      pre_pend_ff <= 1'b0;
    end else if (pre_wr) begin
      pre_rld_ff <= bus_req.wdata;
      if (status_ff) begin
        pre_pend_ff <= 1'b1;
      end else begin
        pre_cnt_ff <= bus_req.wdata;
      end
    end else if (count_en) begin
      if (pre_pend_ff || (pre_cnt_ff == BYTE_ZERO)) begin
        pre_cnt_ff  <= pre_rld_ff;
        pre_pend_ff <= 1'b0;
      end else begin
        pre_cnt_ff <= pre_cnt_ff - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Timer stage
  // ----------------------------------------------------------------
  assign tmr_unf = pre_unf && !tmr_pend_ff && (tmr_cnt_ff == BYTE_ZERO);
  assign per_reload = per_mode && pre_unf &&
                      (per_state_ff == PER_RELOAD);

  always_ff @(posedge ref_clk) begin
    if (!nrst || force_stop) begin
      tmr_cnt_ff  <= CNT_RESET;
      tmr_rld_ff  <= CNT_RESET;
      tmr_pend_ff <= 1'b0;
    end else if (cnt_wr) begin
      tmr_rld_ff <= bus_req.wdata;
      if (status_ff) begin
        tmr_pend_ff <= 1'b1;
      end else begin
        tmr_cnt_ff <= bus_req.wdata;
      end
    end else if (pre_unf) begin
      if (tmr_pend_ff || per_reload || (tmr_cnt_ff == BYTE_ZERO)) begin
        tmr_cnt_ff  <= tmr_rld_ff;
        tmr_pend_ff <= 1'b0;
      end else begin
        tmr_cnt_ff <= tmr_cnt_ff - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Period measurement sequencer and read-out buffer
  // ----------------------------------------------------------------
  logic cnt_rd;
  assign cnt_rd = bus_req.rd && (bus_req.addr == ADDR_CNT);

  always_ff @(posedge ref_clk) begin
    if (!nrst || !status_ff || !per_mode) begin
      per_state_ff <= PER_IDLE;
    end else begin
      case (per_state_ff)
        PER_IDLE: begin
          if (active_edge) begin
            per_state_ff <= PER_LATCH;
          end
        end
        PER_LATCH: begin
          if (pre_unf) begin
            per_state_ff <= PER_RELOAD;
          end
        end
        PER_RELOAD: begin
          if (pre_unf) begin
            per_state_ff <= PER_IDLE;
          end
        end
        default: per_state_ff <= PER_IDLE;
      endcase
    end
  end

  // An unread result is kept; the next period is then dropped
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      buf_ff      <= CNT_RESET;
      buf_held_ff <= 1'b0;
    end else begin
      if (per_mode && pre_unf && (per_state_ff == PER_LATCH) &&
          !buf_held_ff) begin
        buf_ff      <= tmr_cnt_ff;
        buf_held_ff <= 1'b1;
      end else if (cnt_rd) begin
        buf_held_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request and output level
  // ----------------------------------------------------------------
  // Underflow requests in every mode, plain timer mode included
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= tmr_unf || meas_end || per_reload;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      out_lvl_ff <= 1'b0;
    end else if (mode_wr) begin
      out_lvl_ff <= ioc_ff.edge_level_select_bit;
    end else if (tmr_unf && ((mode_ff.op_mode == MODE_PULSE) ||
                             (mode_ff.op_mode == MODE_EVENT))) begin
      out_lvl_ff <= !out_lvl_ff;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers (enables active low while driving)
  // ----------------------------------------------------------------
  logic shared_drv;
  logic inv_drv;
  assign shared_drv = (mode_ff.op_mode == MODE_PULSE) &&
                      !ioc_ff.output_stop_bit;
  assign inv_drv    = ioc_ff.inverted_out_enable_bit &&
                      ((mode_ff.op_mode == MODE_PULSE) ||
                       (mode_ff.op_mode == MODE_EVENT));

  assign pin_a_out  = out_lvl_ff;
  assign pin_b_out  = out_lvl_ff;
  assign pin_a_oe_n = !(shared_drv && !ioc_ff.input_pin_select_bit);
  assign pin_b_oe_n = !(shared_drv && ioc_ff.input_pin_select_bit);
  assign inv_a_out  = !out_lvl_ff;
  assign inv_b_out  = !out_lvl_ff;
  assign inv_a_oe_n = !(inv_drv && !out_pin_select_ff);
  assign inv_b_oe_n = !(inv_drv && out_pin_select_ff);
  assign timer_irq  = irq_ff;

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rdata_ff <= BYTE_ZERO;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        ADDR_CTRL:  rdata_ff <= {2'b00, underflow_ff, edge_found_ff,
                                 2'b00, status_ff, start_ff};
        ADDR_IOC:   rdata_ff <= {2'b00, ioc_ff};
        ADDR_MODE:  rdata_ff <= {2'b00, mode_ff};
        ADDR_PRE:   rdata_ff <= pre_cnt_ff;
        ADDR_CNT:   rdata_ff <= per_mode ? buf_ff : tmr_cnt_ff;
        ADDR_ROUTE: rdata_ff <= {7'h00, out_pin_select_ff};
        default:    rdata_ff <= BYTE_ZERO;
      endcase
    end else begin
      rdata_ff <= BYTE_ZERO;
    end
  end
  assign rdata = rdata_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_latch_step;
    per_mode && pre_unf && (per_state_ff == PER_LATCH);
  endsequence
  sequence s_reload_step;
    per_mode && pre_unf && (per_state_ff == PER_RELOAD);
  endsequence

  chk_force_reset: assert property (
    force_stop |=> (pre_cnt_ff == CNT_RESET) && (tmr_cnt_ff == CNT_RESET)
                   && !start_ff && !status_ff)
    else $error("force stop did not restore counters");

  chk_start_runs: assert property (
    (ctrl_wr && bus_req.wdata[CTRL_START_BIT] && !force_stop)
      ##1 !ctrl_wr |=> status_ff)
    else $error("start bit did not start counting");

  chk_pulse_toggle: assert property (
    (tmr_unf && !mode_wr && mode_ff.op_mode == MODE_PULSE)
      |=> out_lvl_ff != $past(out_lvl_ff))
    else $error("pulse output did not toggle");

  chk_unf_irq: assert property (
    tmr_unf |=> timer_irq && underflow_ff)
    else $error("underflow without interrupt or flag");

  chk_flag_keep: assert property (
    (ctrl_wr && bus_req.wdata[CTRL_UNDF_BIT] && underflow_ff)
      |=> underflow_ff)
    else $error("writing one cleared underflow flag");

  chk_stopped_load: assert property (
    (pre_wr && !status_ff) |=> pre_cnt_ff == $past(bus_req.wdata))
    else $error("stopped write did not load prescaler");

  chk_mode_locked: assert property (
    (mode_wr && !stopped) |=> $stable(mode_ff))
    else $error("mode changed while counting");

  chk_period_seq: assert property (
    s_latch_step ##0 !buf_held_ff |=> (buf_ff == $past(tmr_cnt_ff)) &&
      (per_state_ff == PER_RELOAD))
    else $error("period latch step skipped");

  chk_period_reload: assert property (
    s_reload_step |=> timer_irq && edge_found_ff)
    else $error("period reload without irq or flag");

  chk_inv_pin: assert property (
    !inv_a_oe_n |-> (inv_a_out == !pin_a_out))
    else $error("inverted pin not complement");

  chk_buf_hold: assert property (
    (buf_held_ff && !cnt_rd) |=> $stable(buf_ff))
    else $error("held read-out buffer changed");

endmodule // reload_timer

/* File: test/pin_source.sv */
// Pulse source and load on the two shared timer input routes
`timescale 1ns/1ps
module pin_source (
  input  wire logic ref_clk,
  input  wire logic lvl,
  input  wire logic sel_b,
  input  wire logic pin_a_out,
  input  wire logic pin_a_oe_n,
  input  wire logic pin_b_out,
  input  wire logic pin_b_oe_n,
  output logic      pin_a_in,
  output logic      pin_b_in
);
  logic tgl = 1'b0;

  // Unused route wiggles every cycle so a wrong route shows up
  always @(posedge ref_clk) tgl <= ~tgl;

  // A driving timer owns the wire, otherwise the source does
  assign pin_a_in = !pin_a_oe_n ? pin_a_out : (sel_b ? tgl : lvl);
  assign pin_b_in = !pin_b_oe_n ? pin_b_out : (sel_b ? lvl : tgl);
endmodule // pin_source

/* File: test/reload_timer_bench.sv */
// Self-checking bench for the prescaled reload timer
`timescale 1ns/1ps
module reload_timer_bench;
  import timer_pkg::*;
  logic       ref_clk = 1'b0;
  logic       nrst = 1'b0;
  reg_req_t   bus_req = '0;
  logic       osc = 1'b0;
  // Subclock ticks every cycle, so its /32 source ticks every 32
  logic       sub_tick = 1'b1;
  logic       lvl = 1'b0;
  logic       sel_b = 1'b0;
  logic [7:0] rdata;
  logic       pa_in, pa_out, pa_oe_n, pb_in, pb_out, pb_oe_n;
  logic       ia_out, ia_oe_n, ib_out, ib_oe_n, irq, p;
  logic [7:0] v;
  int         error_cnt = 0;
  int         samples_checked = 0;
  int         irqs = 0;
  int         cyc = 0;
  int         snap;
  clk_src_t   srcs[5] = '{SRC_SUB32, SRC_ONCHIP, SRC_DIV_EIGHT,
                          SRC_DIV_TWO, SRC_DIV_ONE};
  int         divs[5] = '{32, 4, 8, 2, 1};

  reload_timer reload_timer_inst (.ref_clk(ref_clk), .nrst(nrst),
    .bus_req(bus_req), .rdata(rdata), .onchip_osc_clock(osc),
    .subclock_tick(sub_tick), .pin_a_in(pa_in), .pin_a_out(pa_out),
    .pin_a_oe_n(pa_oe_n), .pin_b_in(pb_in), .pin_b_out(pb_out),
    .pin_b_oe_n(pb_oe_n), .inv_a_out(ia_out), .inv_a_oe_n(ia_oe_n),
    .inv_b_out(ib_out), .inv_b_oe_n(ib_oe_n), .timer_irq(irq));

  pin_source pin_source_inst (.ref_clk(ref_clk), .lvl(lvl), .sel_b(sel_b),
    .pin_a_out(pa_out), .pin_a_oe_n(pa_oe_n), .pin_b_out(pb_out),
    .pin_b_oe_n(pb_oe_n), .pin_a_in(pa_in), .pin_b_in(pb_in));

  always #50 ref_clk = ~ref_clk;

  // Counting on the falling edge keeps it clear of the bench's snapshots
  always @(negedge ref_clk) if (irq === 1'b1) irqs++;

  always @(posedge ref_clk) begin
    cyc++;
    osc <= (cyc % 4 == 0);
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Access and check tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string m);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [2:0] a, input logic [7:0] exp,
                        input string m);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    @(negedge ref_clk);
    check(rdata, exp, m);
  endtask

  task automatic irq_window(input int n, input int exp, input string m);
    @(posedge ref_clk);
    snap = irqs;
    cycles(n);
    check(8'(irqs - snap), 8'(exp), m);
  endtask

  // Force stop sets counters back to FF, so every setup starts from a known state
  task automatic setup(input logic [7:0] md, input logic [7:0] ioc,
                       input logic [7:0] pre, input logic [7:0] cnt);
    wr(ADDR_CTRL, 8'h04);
    wr(ADDR_IOC, ioc);
    wr(ADDR_MODE, md);
    wr(ADDR_PRE, pre);
    wr(ADDR_CNT, cnt);
    wr(ADDR_CTRL, 8'h01);
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    cycles(6);
    nrst <= 1'b1;
    chk_rd(ADDR_PRE, CNT_RESET, "pre reset");
    chk_rd(ADDR_CNT, CNT_RESET, "cnt reset");
    chk_rd(3'h7, 8'h00, "unmapped read");
    wr(ADDR_PRE, 8'h5A);
    chk_rd(ADDR_PRE, 8'h5A, "pre load");
    foreach (srcs[i]) begin
      setup({2'b00, srcs[i], MODE_PULSE}, 8'h04, 8'h01, 8'h01);
      cycles(12);
      irq_window(128, 32 / divs[i], "irq per source");
    end
    @(negedge ref_clk);
    check(8'({pa_oe_n, pb_oe_n}), 8'h01, "pin driven");
    check(8'(ia_out), 8'(!pa_out), "inverse out");
    snap = 0;
    p = pa_out;
    repeat (4) begin
      @(negedge ref_clk);
      if (pa_out !== p) snap++;
      p = pa_out;
    end
    check(8'(snap), 8'h01, "toggle per underflow");
    wr(ADDR_ROUTE, 8'h01);
    @(negedge ref_clk);
    check(8'({ia_oe_n, ib_oe_n}), 8'h02, "out route");
    wr(ADDR_ROUTE, 8'h00);
    wr(ADDR_IOC, 8'h06);
    @(negedge ref_clk);
    check(8'(pa_oe_n), 8'h01, "output stop");
    irq_window(16, 4, "count on while stopped");
    wr(ADDR_CTRL, 8'h20);
    cycles(4);
    chk_rd(ADDR_CTRL, 8'h20, "flag kept");
    irq_window(20, 0, "halted");
    wr(ADDR_CTRL, 8'h00);
    chk_rd(ADDR_CTRL, 8'h00, "flag cleared");
    for (int e = 0; e < 2; e++) begin
      wr(ADDR_IOC, 8'(e));
      wr(ADDR_MODE, 8'h01);
      @(negedge ref_clk);
      check(8'(pa_out), 8'(e), "start level");
    end
    wr(ADDR_CTRL, 8'h01);
    cycles(10);
    wr(ADDR_CTRL, 8'h04);
    chk_rd(ADDR_PRE, CNT_RESET, "pre forced");
    chk_rd(ADDR_CNT, CNT_RESET, "cnt forced");
    irq_window(20, 0, "forced stop");
    sel_b <= 1'b1;
    setup(8'h02, 8'h0C, 8'h02, 8'h00);
    @(posedge ref_clk);
    snap = irqs;
    repeat (6) begin
      lvl <= 1'b1;
      cycles(8);
      lvl <= 1'b0;
      cycles(8);
    end
    check(8'(irqs - snap), 8'h02, "event count");
    check(8'({ia_oe_n, ib_oe_n}), 8'h01, "event inv out");
    sel_b <= 1'b0;
    setup(8'h03, 8'h00, 8'h00, 8'hFF);
    cycles(10);
    chk_rd(ADDR_CNT, 8'hFF, "no count while low");
    wr(ADDR_MODE, 8'h01);
    chk_rd(ADDR_MODE, 8'h03, "mode locked");
    @(posedge ref_clk);
    snap = irqs;
    lvl <= 1'b1;
    cycles(20);
    lvl <= 1'b0;
    cycles(12);
    check(8'(irqs - snap), 8'h01, "width end irq");
    chk_rd(ADDR_CNT, 8'hEB, "width count");
    // Period mode, filter at full rate, rising edges 40 cycles apart
    setup(8'h04, 8'h10, 8'h01, 8'hFF);
    snap = irqs;
    repeat (3) begin
      lvl <= 1'b1;
      cycles(20);
      lvl <= 1'b0;
      cycles(20);
    end
    check(8'(irqs - snap), 8'h06, "period irqs");
    chk_rd(ADDR_CTRL, 8'h13, "edge found");
    // First result stays held; later periods are dropped until read
    chk_rd(ADDR_CNT, 8'hFD, "first period held");
    @(posedge ref_clk);
    lvl <= 1'b1;
    cycles(20);
    lvl <= 1'b0;
    cycles(20);
    chk_rd(ADDR_CNT, 8'hEA, "period latched");
    complete_run();
  end
endmodule // reload_timer_bench
